//--- inc/epe_consts.svh
`ifndef EPE_CONSTS_SVH
`define EPE_CONSTS_SVH

// exception numbers
`define EPE_NUM_EXC       24
`define EPE_NUM_IRQ       8
`define EPE_EXC_NONE      5'h00
`define EPE_EXC_RESET     5'h01
`define EPE_EXC_NMI       5'h02
`define EPE_EXC_HARD      5'h03
`define EPE_EXC_SVC       5'h0B
`define EPE_EXC_PENDABLE_SERVICE_REQUEST    5'h0E
`define EPE_EXC_TICK      5'h0F
`define EPE_EXC_IRQ0      5'h10

// encoded levels: encoded = printed priority + 3, lower is more urgent
`define EPE_LVL_RESET     3'h0
`define EPE_LVL_NMI       3'h1
`define EPE_LVL_HARD      3'h2
`define EPE_LVL_CFG_BIAS  3'h3
`define EPE_LVL_THREAD    3'h7

// vector table
`define EPE_VEC_BASE      32'h0000_0000
`define EPE_VEC_MSP       32'h0000_0000
`define EPE_VEC_RESET     32'h0000_0004
`define EPE_VEC_IRQ0      32'h0000_0040

// stack frame
`define EPE_FRAME_LAST    3'h7
`define EPE_FRAME_BYTES   32'h0000_0020
`define EPE_REG_PC        3'h0
`define EPE_REG_PSW       3'h1
`define EPE_REG_LINK      3'h7

`endif

//--- inc/epe_pkg.sv
package epe_pkg;

	typedef enum {
		ST_RESET_SP,
		ST_RESET_PC,
		ST_RUN,
		ST_PUSH,
		ST_VECTOR,
		ST_POP
	} epe_state_t;

	typedef logic [4:0] epe_num_t;
	typedef logic [2:0] epe_lvl_t;
	typedef logic [2:0] epe_reg_t;

endpackage

//--- rtl/epe_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for pin inputs
module epe_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_reset_n,
	// data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			meta <= RST_VAL;
			o_q  <= RST_VAL;
		end
		else
		begin
			meta <= i_d;
			o_q  <= meta;
		end
	end

endmodule

//--- rtl/epe_arbiter.sv
`timescale 1ns/1ps
`include "epe_consts.svh"

// picks the most urgent pending exception
module epe_arbiter (
	// pending requests and their encoded levels
	input  wire logic [`EPE_NUM_EXC-1:0]   i_pend,
	input  wire logic [3*`EPE_NUM_EXC-1:0] i_lvl,
	// winner
	output logic                           o_found,
	output epe_pkg::epe_num_t              o_num,
	output epe_pkg::epe_lvl_t              o_lvl
);

	always_comb
	begin
		o_found = 1'b0;
		o_num   = `EPE_EXC_NONE;
		o_lvl   = `EPE_LVL_THREAD;
		// ascending scan, strict compare keeps the lower number on a tie
		for (int i = 0; i < `EPE_NUM_EXC; i++)
		begin
			if (i_pend[i] && (!o_found || i_lvl[3*i +: 3] < o_lvl))
			begin
				o_found = 1'b1;
				o_num   = 5'(i);
				o_lvl   = i_lvl[3*i +: 3];
			end
		end
	end

endmodule

//--- rtl/epe_exception_priority_entry.sv
`timescale 1ns/1ps
`include "epe_consts.svh"

// Summary of operation
// - Of simultaneous requests the most urgent one is serviced first, the others stay pending.
// - Reset is fixed at -3 from pin, watchdog or software; NMI at -2.
// - A fault is raised as hard fault at -1; one that cannot be taken locks up.
// - Supervisor call instruction raises exception 11 at software level.
// - Pendable service request is exception 14 at software level.
// - System tick notification is exception 15 at software level.
// - Pins and peripherals map to exceptions 16 upward, software levels.
// - Configurable levels are 2-bit, 0 to 3, 0 most urgent.
// - On equal levels the lower exception number wins.
// - External levels from irq priority fields, others from handler fields.
// - No-execute fetch or fault region access raises an exception.
// - Exception instructions and execution errors raise an exception.
// - Entry pushes PC, status word, r0-r3, r12, link in that order.
// - Stack pointer is lowered by eight words once the push ends.
// - After stacking the core is held and branches to the handler.
// - Handler completion restores the saved state without software.
// - Handler addresses come from the vector table; SP 0x00, reset 0x04.
// - Return pops eight words, raises SP, recovers active number.
module epe_exception_priority_entry (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	// reset exception sources
	input  wire logic        i_rst_pin_n,
	input  wire logic        i_watchdog_timer_source_reset,
	input  wire logic        i_software_reset_request,
	// non-maskable sources
	input  wire logic        i_nmi_pin,
	input  wire logic        i_watchdog_timer_source_nmi,
	// fault and instruction sources
	input  wire logic        i_fetch_no_execute_region,
	input  wire logic        i_fault_region_violation,
	input  wire logic        i_instr_exception,
	input  wire logic        i_exec_error,
	// system exception sources
	input  wire logic        i_supervisor_call_exception,
	input  wire logic        i_pendable_service_request,
	input  wire logic        i_systick_req,
	// external interrupt pins
	input  wire logic [7:0]  i_irq_pin,
	// priority level fields
	input  wire logic [1:0]  i_svc_priority_level_field,
	input  wire logic [1:0]  i_pendable_service_request_priority_level_field,
	input  wire logic [1:0]  i_systick_priority_level_field,
	input  wire logic [15:0] i_irq_priority_level_field,
	// core side
	input  wire logic        i_exc_return,
	input  wire logic [31:0] i_core_reg_data,
	input  wire logic [31:0] i_sp,
	output logic      [2:0]  o_core_reg_sel,
	output logic             o_restore_we,
	output logic      [2:0]  o_restore_sel,
	output logic      [31:0] o_restore_data,
	output logic             o_sp_we,
	output logic      [31:0] o_sp_value,
	output logic             o_core_halt,
	output logic             o_branch_valid,
	output logic      [31:0] o_branch_addr,
	output logic      [4:0]  o_active_num,
	output logic             o_lockup,
	// memory side
	output logic             o_mem_req,
	output logic             o_mem_we,
	output logic      [31:0] o_mem_addr,
	output logic      [31:0] o_mem_wdata,
	input  wire logic        i_mem_ack,
	input  wire logic [31:0] i_mem_rdata
);

	epe_pkg::epe_state_t           state;
	logic [9:0]                    pin_sync;
	logic                          rst_pin_prev;
	logic                          nmi_prev;
	logic                          rst_req;
	logic                          nmi_req;
	logic                          fault_req;
	logic                          fault_blocked;
	logic [3*`EPE_NUM_EXC-1:0]     lvl_flat;
	epe_pkg::epe_lvl_t             active_lvl;
	logic [`EPE_NUM_EXC-1:0]       pend;
	logic [`EPE_NUM_EXC-1:0]       set_vec;
	logic [`EPE_NUM_EXC-1:0]       clr_vec;
	logic                          arb_found;
	epe_pkg::epe_num_t             arb_num;
	epe_pkg::epe_lvl_t             arb_lvl;
	logic                          preempt;
	logic                          take;
	logic                          vec_done;
	logic                          pop_psw;
	epe_pkg::epe_num_t             sel_num;
	logic [2:0]                    word_idx;
	logic [31:0]                   frame_base;
	logic [31:0]                   vec_addr;

	// push order index to word slot above the new stack pointer
	function automatic logic [2:0] stack_slot(input logic [2:0] k);
		logic [2:0] s;
		s = 3'h0;
		unique case (k)
			`EPE_REG_PC:  s = 3'h6;
			`EPE_REG_PSW: s = 3'h7;
			default:      s = k - 3'h2;
		endcase
		return s;
	endfunction

	epe_sync #(
		.W       (10),
		.RST_VAL (10'h200)
	) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_d       ({i_rst_pin_n, i_nmi_pin, i_irq_pin}),
		.o_q       (pin_sync)
	);

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			rst_pin_prev <= 1'b1;
			nmi_prev     <= 1'b0;
		end
		else
		begin
			rst_pin_prev <= pin_sync[9];
			nmi_prev     <= pin_sync[8];
		end
	end

	// reset pin acts on its low-to-high edge
	assign rst_req = (pin_sync[9] & ~rst_pin_prev)
		| i_watchdog_timer_source_reset
		| i_software_reset_request;
	assign nmi_req = (pin_sync[8] & ~nmi_prev)
		| i_watchdog_timer_source_nmi;
	assign fault_req = i_fetch_no_execute_region | i_fault_region_violation
		| i_instr_exception | i_exec_error;

	// encoded level per exception number
	always_comb
	begin
		lvl_flat = {`EPE_NUM_EXC{`EPE_LVL_THREAD}};
		lvl_flat[3*`EPE_EXC_RESET +: 3]  = `EPE_LVL_RESET;
		lvl_flat[3*`EPE_EXC_NMI +: 3]    = `EPE_LVL_NMI;
		lvl_flat[3*`EPE_EXC_HARD +: 3]   = `EPE_LVL_HARD;
		lvl_flat[3*`EPE_EXC_SVC +: 3]    = {1'b0, i_svc_priority_level_field}
			+ `EPE_LVL_CFG_BIAS;
		lvl_flat[3*`EPE_EXC_PENDABLE_SERVICE_REQUEST +: 3] =
			{1'b0, i_pendable_service_request_priority_level_field}
			+ `EPE_LVL_CFG_BIAS;
		lvl_flat[3*`EPE_EXC_TICK +: 3]   =
			{1'b0, i_systick_priority_level_field}
			+ `EPE_LVL_CFG_BIAS;
		for (int i = 0; i < `EPE_NUM_IRQ; i++)
		begin
			lvl_flat[3*(`EPE_EXC_IRQ0 + i) +: 3] =
				{1'b0, i_irq_priority_level_field[2*i +: 2]}
				+ `EPE_LVL_CFG_BIAS;
		end
	end

	assign active_lvl = (o_active_num == `EPE_EXC_NONE) ? `EPE_LVL_THREAD
		: lvl_flat[3*o_active_num +: 3];

	// faults escalate to hard fault unless already at -1 or above
	assign fault_blocked = fault_req & (active_lvl <= `EPE_LVL_HARD);

	always_comb
	begin
		set_vec = '0;
		set_vec[`EPE_EXC_NMI]    = nmi_req;
		set_vec[`EPE_EXC_HARD]   = fault_req & ~fault_blocked;
		set_vec[`EPE_EXC_SVC]    = i_supervisor_call_exception;
		set_vec[`EPE_EXC_PENDABLE_SERVICE_REQUEST] = i_pendable_service_request;
		set_vec[`EPE_EXC_TICK]   = i_systick_req;
		set_vec[`EPE_EXC_IRQ0 +: `EPE_NUM_IRQ] = pin_sync[7:0];
	end

	always_comb
	begin
		clr_vec = '0;
		if (take)
			clr_vec[arb_num] = 1'b1;
	end

	// pending flags, a new request wins over the clear
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || rst_req)
			pend <= '0;
		else
			pend <= (pend & ~clr_vec) | set_vec;
	end

	epe_arbiter u_arb (
		.i_pend  (pend),
		.i_lvl   (lvl_flat),
		.o_found (arb_found),
		.o_num   (arb_num),
		.o_lvl   (arb_lvl)
	);

	assign preempt = arb_found && (arb_lvl < active_lvl) && !o_lockup;

	// winner is chosen again at end of push, so a late arrival goes first
	assign take = (state == epe_pkg::ST_PUSH) && o_mem_req && i_mem_ack
		&& (word_idx == `EPE_FRAME_LAST) && arb_found;
	assign vec_done = (state == epe_pkg::ST_VECTOR) && o_mem_req
		&& i_mem_ack;
	assign pop_psw = (state == epe_pkg::ST_POP) && o_mem_req && i_mem_ack
		&& (word_idx == `EPE_REG_PSW);

	assign vec_addr = (sel_num >= `EPE_EXC_IRQ0)
		? `EPE_VEC_BASE + `EPE_VEC_IRQ0
			+ {25'h0000000, sel_num - `EPE_EXC_IRQ0, 2'h0}
		: `EPE_VEC_BASE + {25'h0000000, sel_num, 2'h0};

	// active exception number
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || rst_req)
			o_active_num <= `EPE_EXC_NONE;
		else if (vec_done)
			o_active_num <= sel_num;
		else if (pop_psw)
			o_active_num <= i_mem_rdata[4:0];
	end

	// lockup on a fault that even hard fault cannot take
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || rst_req)
			o_lockup <= 1'b0;
		else if (fault_blocked)
			o_lockup <= 1'b1;
	end

	// entry, vector fetch and return sequencing
	always_ff @(posedge i_sys_clk)
	begin
		o_sp_we        <= 1'b0;
		o_branch_valid <= 1'b0;
		o_restore_we   <= 1'b0;
		if (!i_reset_n || rst_req)
		begin
			state          <= epe_pkg::ST_RESET_SP;
			o_core_halt    <= 1'b1;
			o_mem_req      <= 1'b0;
			o_mem_we       <= 1'b0;
			o_mem_addr     <= 32'h0000_0000;
			o_mem_wdata    <= 32'h0000_0000;
			o_core_reg_sel <= `EPE_REG_PC;
			o_restore_sel  <= `EPE_REG_PC;
			o_restore_data <= 32'h0000_0000;
			o_sp_value     <= 32'h0000_0000;
			o_branch_addr  <= 32'h0000_0000;
			word_idx       <= 3'h0;
			frame_base     <= 32'h0000_0000;
			sel_num        <= `EPE_EXC_NONE;
		end
		else
		begin
			unique case (state)
				epe_pkg::ST_RESET_SP:
				begin
					if (o_mem_req)
					begin
						if (i_mem_ack)
						begin
							o_mem_req  <= 1'b0;
							o_sp_we    <= 1'b1;
							o_sp_value <= i_mem_rdata;
							state      <= epe_pkg::ST_RESET_PC;
						end
					end
					else
					begin
						o_mem_req  <= 1'b1;
						o_mem_we   <= 1'b0;
						o_mem_addr <= `EPE_VEC_BASE + `EPE_VEC_MSP;
					end
				end
				epe_pkg::ST_RESET_PC:
				begin
					if (o_mem_req)
					begin
						if (i_mem_ack)
						begin
							o_mem_req      <= 1'b0;
							o_branch_valid <= 1'b1;
							o_branch_addr  <= i_mem_rdata;
							o_core_halt    <= 1'b0;
							state          <= epe_pkg::ST_RUN;
						end
					end
					else
					begin
						o_mem_req  <= 1'b1;
						o_mem_we   <= 1'b0;
						o_mem_addr <= `EPE_VEC_BASE + `EPE_VEC_RESET;
					end
				end
				epe_pkg::ST_RUN:
				begin
					word_idx       <= 3'h0;
					o_core_reg_sel <= `EPE_REG_PC;
					// a return already under way is finished before pre-emption
					if (i_exc_return && o_active_num != `EPE_EXC_NONE)
					begin
						o_core_halt <= 1'b1;
						frame_base  <= i_sp;
						state       <= epe_pkg::ST_POP;
					end
					// core loads a new stack pointer one edge after the strobe
					else if (preempt && !o_sp_we)
					begin
						o_core_halt <= 1'b1;
						frame_base  <= i_sp - `EPE_FRAME_BYTES;
						state       <= epe_pkg::ST_PUSH;
					end
				end
				epe_pkg::ST_PUSH:
				begin
					if (o_mem_req)
					begin
						if (i_mem_ack)
						begin
							o_mem_req <= 1'b0;
							if (word_idx == `EPE_FRAME_LAST)
							begin
								o_sp_we    <= 1'b1;
								o_sp_value <= frame_base;
								sel_num    <= arb_num;
								state      <= epe_pkg::ST_VECTOR;
							end
							else
							begin
								word_idx       <= word_idx + 3'h1;
								o_core_reg_sel <= word_idx + 3'h1;
							end
						end
					end
					else
					begin
						o_mem_req  <= 1'b1;
						o_mem_we   <= 1'b1;
						o_mem_addr <= frame_base
							+ {27'h0000000, stack_slot(word_idx), 2'h0};
						// saved status word carries the interrupted number
						if (word_idx == `EPE_REG_PSW)
							o_mem_wdata <= {i_core_reg_data[31:5], o_active_num};
						else
							o_mem_wdata <= i_core_reg_data;
					end
				end
				epe_pkg::ST_VECTOR:
				begin
					if (o_mem_req)
					begin
						if (i_mem_ack)
						begin
							o_mem_req      <= 1'b0;
							o_branch_valid <= 1'b1;
							o_branch_addr  <= i_mem_rdata;
							o_core_halt    <= 1'b0;
							state          <= epe_pkg::ST_RUN;
						end
					end
					else
					begin
						o_mem_req  <= 1'b1;
						o_mem_we   <= 1'b0;
						o_mem_addr <= vec_addr;
					end
				end
				epe_pkg::ST_POP:
				begin
					if (o_mem_req)
					begin
						if (i_mem_ack)
						begin
							o_mem_req      <= 1'b0;
							o_restore_we   <= 1'b1;
							o_restore_sel  <= word_idx;
							o_restore_data <= i_mem_rdata;
							if (word_idx == `EPE_FRAME_LAST)
							begin
								o_sp_we     <= 1'b1;
								o_sp_value  <= frame_base + `EPE_FRAME_BYTES;
								o_core_halt <= 1'b0;
								state       <= epe_pkg::ST_RUN;
							end
							else
								word_idx <= word_idx + 3'h1;
						end
					end
					else
					begin
						o_mem_req  <= 1'b1;
						o_mem_we   <= 1'b0;
						o_mem_addr <= frame_base
							+ {27'h0000000, stack_slot(word_idx), 2'h0};
					end
				end
			endcase
		end
	end

endmodule

//--- verif/epe_chk.sv
`timescale 1ns/1ps

module epe_chk (
	// watched ports
	input wire logic        i_sys_clk,
	input wire logic        i_reset_n,
	input wire logic        i_software_reset_request,
	input wire logic [31:0] i_sp,
	input wire logic        i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic [31:0] o_mem_addr,
	input wire logic        o_core_halt,
	input wire logic        o_branch_valid,
	input wire logic [31:0] o_branch_addr,
	input wire logic [4:0]  o_active_num,
	input wire logic        o_lockup,
	input wire logic        o_sp_we,
	input wire logic [31:0] o_sp_value,
	input wire logic        o_restore_we
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// kind of the last completed transfer
	logic last_wr;
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			last_wr <= 1'b0;
		else if (o_mem_req && i_mem_ack)
			last_wr <= o_mem_we;
	end
	property p_rst;
		disable iff (1'b0) !i_reset_n |=> o_core_halt && !o_mem_req;
	endproperty
	a_rst: assert property (p_rst) else $error("reset outputs wrong");
	property p_active_rst;
		$rose(i_reset_n) |-> o_active_num == 5'h00 && !o_lockup;
	endproperty
	a_active_rst: assert property (p_active_rst) else $error("not thread");
	// lockup leaves only together with a reset of the sequencer
	property p_lock;
		o_lockup |=> o_lockup
			|| (o_core_halt && !o_mem_req && o_active_num == 5'h00);
	endproperty
	a_lock: assert property (p_lock) else $error("lockup dropped");
	property p_sw_rst;
		i_software_reset_request |=> o_core_halt && !o_mem_req
			&& o_active_num == 5'h00 && !o_lockup;
	endproperty
	a_sw_rst: assert property (p_sw_rst) else $error("sw reset");
	property p_first_push;
		$rose(o_mem_req) && o_mem_we && !last_wr |-> o_mem_addr == i_sp - 32'h8;
	endproperty
	a_first_push: assert property (p_first_push) else $error("pc slot");
	property p_sp_push;
		o_sp_we && last_wr |-> o_sp_value == i_sp - 32'h20;
	endproperty
	a_sp_push: assert property (p_sp_push) else $error("sp not -32");
	property p_branch_vec;
		o_branch_valid |-> $past(o_mem_addr) == ((o_active_num == 5'h00) ?
			32'h4 : {25'h0, o_active_num, 2'h0});
	endproperty
	a_branch_vec: assert property (p_branch_vec) else $error("vector");
	property p_branch_data;
		o_branch_valid |-> o_branch_addr == $past(i_mem_rdata) ##1 !o_branch_valid;
	endproperty
	a_branch_data: assert property (p_branch_data) else $error("branch");
	property p_restore;
		o_restore_we |-> $past(o_mem_req && i_mem_ack && !o_mem_we);
	endproperty
	a_restore: assert property (p_restore) else $error("restore");
	property p_halt;
		o_mem_req |-> o_core_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("core not held");
endmodule

bind epe_exception_priority_entry epe_chk epe_chk_inst (
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
	.i_software_reset_request(i_software_reset_request), .i_sp(i_sp),
	.i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_mem_req(o_mem_req),
	.o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_core_halt(o_core_halt),
	.o_branch_valid(o_branch_valid), .o_branch_addr(o_branch_addr),
	.o_active_num(o_active_num), .o_lockup(o_lockup), .o_sp_we(o_sp_we),
	.o_sp_value(o_sp_value), .o_restore_we(o_restore_we)
);

//--- verif/epe_mem_model.sv
`timescale 1ns/1ps

// vector table plus stack ram, ack after i_lat idle cycles
module epe_mem_model #(
	parameter logic [31:0] STACK_TOP = 32'h2000_1000
) (
	input  wire logic        i_sys_clk,
	input  wire logic [1:0]  i_lat,
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	output logic             o_ack,
	output logic      [31:0] o_rdata
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] wr_a [$];
	logic [31:0] wr_d [$];
	logic [1:0]  cnt = 2'h0;
	initial o_ack = 1'b0;
	initial o_rdata = 32'h0000_0000;
	always @(posedge i_sys_clk)
	begin
		if (o_ack || !i_req)
		begin
			o_ack <= 1'b0;
			cnt <= 2'h0;
			o_rdata <= ~o_rdata; // released bus inverts the last word on every cycle
		end
		else if (cnt != i_lat)
			cnt <= cnt + 2'h1;
		else
		begin
			o_ack <= 1'b1;
			if (i_we)
			begin
				mem[i_addr] = i_wdata;
				wr_a.push_back(i_addr);
				wr_d.push_back(i_wdata);
			end
			else if (mem.exists(i_addr))
				o_rdata <= mem[i_addr];
			else
				o_rdata <= (i_addr == 32'h0) ? STACK_TOP : 32'h8000_0000 | i_addr;
		end
	end
endmodule

//--- verif/tb_epe_exception_priority_entry.sv
`timescale 1ns/1ps
`include "epe_consts.svh"

module tb_epe_exception_priority_entry;
	typedef struct packed {
		logic [9:0] src;
		logic [9:0] lv;
		logic [4:0] num;
	} epe_row_t;
	localparam logic [31:0] STACK_TOP = 32'h2000_1000;
	logic        clk, rst_n, rpin_n, sw_rst, wd_rst, wd_nmi, svc, psv, tick;
	logic        ret, f_nx, f_reg, f_ins, f_err, ack, hlt, br, lock, sp_we;
	logic        m_req, m_we, rs_we, nmi;
	logic [7:0]  irq;
	logic [1:0]  lsvc, lpsv, ltick, lat;
	logic [15:0] lirq;
	logic [31:0] sp, rdata, br_addr, sp_val, m_addr, m_wdata, old;
	logic [31:0] rs_data;
	logic [4:0]  act;
	logic [2:0]  sel, rs_sel;
	int          fail_count, total_checks, cycles;
	epe_row_t    rows [13];

	epe_exception_priority_entry epe_exception_priority_entry_inst (
		.i_sys_clk(clk), .i_reset_n(rst_n), .i_rst_pin_n(rpin_n),
		.i_watchdog_timer_source_reset(wd_rst), .i_software_reset_request(sw_rst),
		.i_nmi_pin(nmi), .i_watchdog_timer_source_nmi(wd_nmi),
		.i_fetch_no_execute_region(f_nx), .i_fault_region_violation(f_reg),
		.i_instr_exception(f_ins), .i_exec_error(f_err),
		.i_supervisor_call_exception(svc), .i_pendable_service_request(psv),
		.i_systick_req(tick), .i_irq_pin(irq), .i_svc_priority_level_field(lsvc),
		.i_pendable_service_request_priority_level_field(lpsv),
		.i_systick_priority_level_field(ltick), .i_irq_priority_level_field(lirq),
		.i_exc_return(ret), .i_core_reg_data({24'hC0DE00, sel, 5'h00}),
		.i_sp(sp), .o_core_reg_sel(sel), .o_restore_we(rs_we),
		.o_restore_sel(rs_sel), .o_restore_data(rs_data), .o_sp_we(sp_we),
		.o_sp_value(sp_val),
		.o_core_halt(hlt), .o_branch_valid(br), .o_branch_addr(br_addr),
		.o_active_num(act), .o_lockup(lock), .o_mem_req(m_req), .o_mem_we(m_we),
		.o_mem_addr(m_addr), .o_mem_wdata(m_wdata), .i_mem_ack(ack),
		.i_mem_rdata(rdata)
	);
	epe_mem_model #(.STACK_TOP(STACK_TOP)) epe_mem_model_inst (
		.i_sys_clk(clk), .i_lat(lat), .i_req(m_req), .i_we(m_we),
		.i_addr(m_addr), .i_wdata(m_wdata), .o_ack(ack), .o_rdata(rdata)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// core keeps the stack pointer that the unit hands back
	always @(posedge clk)
	begin
		cycles++;
		if (sp_we === 1'b1)
			sp <= sp_val;
		// popped word must come back to the register it was pushed from
		if (rs_we === 1'b1)
			check(rs_data[31:5], {24'hC0DE00, rs_sel});
		if (cycles == 20000)
		begin
			fail_count++;
			close_out;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("checks=%0d errors=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task step;
		@(posedge clk);
		#2;
	endtask
	task pulse(input logic [9:0] s);
		{f_err, f_reg, f_nx, f_ins, wd_nmi, irq[1:0], tick, psv, svc} = s;
		step;
		{f_err, f_reg, f_nx, f_ins, wd_nmi, irq[1:0], tick, psv, svc} = 10'h000;
	endtask
	task wait_br;
		for (int n = 0; n < 300 && br !== 1'b1; n++)
			step;
	endtask
	// four quiet cycles in a row
	task wait_idle;
		int q;
		q = 0;
		for (int n = 0; n < 400 && q < 4; n++)
		begin
			step;
			q = (hlt === 1'b0) ? q + 1 : 0;
		end
	endtask
	task drain;
		for (int i = 0; i < 8 && act !== 5'h00; i++)
		begin
			ret = 1'b1;
			step;
			ret = 1'b0;
			wait_idle;
		end
	endtask
	task enter(input logic [9:0] s);
		old = sp;
		epe_mem_model_inst.wr_a.delete();
		epe_mem_model_inst.wr_d.delete();
		pulse(s);
		wait_br;
	endtask
	task chk_push(input logic [4:0] prev);
		logic [31:0] a [8];
		a = '{32'h18, 32'h1C, 32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h14};
		check(32'(epe_mem_model_inst.wr_a.size()), 32'h8);
		for (int k = 0; k < 8; k++)
		begin
			check(epe_mem_model_inst.wr_a[k], old - 32'h20 + a[k]);
			check(epe_mem_model_inst.wr_d[k],
				{24'hC0DE00, k[2:0], (k == 1) ? prev : 5'h00});
		end
	endtask

	initial
	begin
		{rst_n, sw_rst, wd_rst, ret, irq, lat} = 14'h0000;
		{lsvc, lpsv, ltick, lirq} = 22'h000000;
		{f_err, f_reg, f_nx, f_ins, wd_nmi, tick, psv, svc} = 8'h00;
		{rpin_n, nmi} = 2'h2;
		sp = 32'h2000_0800;
		rows[0] = '{10'h001, 10'h002, `EPE_EXC_SVC};
		rows[1] = '{10'h002, 10'h000, `EPE_EXC_PENDABLE_SERVICE_REQUEST};
		rows[2] = '{10'h004, 10'h030, `EPE_EXC_TICK};
		rows[3] = '{10'h008, 10'h000, `EPE_EXC_IRQ0};
		rows[4] = '{10'h010, 10'h300, 5'h11};
		rows[5] = '{10'h007, 10'h015, `EPE_EXC_SVC};
		rows[6] = '{10'h005, 10'h003, `EPE_EXC_TICK};
		rows[7] = '{10'h018, 10'h180, 5'h11};
		rows[8] = '{10'h021, 10'h000, `EPE_EXC_NMI};
		rows[9] = '{10'h048, 10'h000, `EPE_EXC_HARD};
		rows[10] = '{10'h080, 10'h000, `EPE_EXC_HARD};
		rows[11] = '{10'h100, 10'h000, `EPE_EXC_HARD};
		rows[12] = '{10'h200, 10'h000, `EPE_EXC_HARD};
		repeat (6) step;
		check(hlt, 1'b1);
		check(m_req, 1'b0);
		rst_n = 1'b1;
		wait_br;
		check(br_addr, 32'h8000_0004);
		check(sp, STACK_TOP);
		step;
		for (int r = 0; r < 13; r++)
		begin
			lat = 2'(r % 3);
			{lirq[3:0], ltick, lpsv, lsvc} = rows[r].lv;
			enter(rows[r].src);
			check(br_addr, 32'h8000_0000 | {rows[r].num, 2'h0});
			check(act, rows[r].num);
			chk_push(5'h00);
			drain;
			check(act, 5'h00);
			check(sp, old);
		end
		// nmi pin edge
		nmi = 1'b1;
		enter(10'h000);
		check(br_addr, 32'h8000_0008);
		check(act, `EPE_EXC_NMI);
		chk_push(5'h00);
		nmi = 1'b0;
		drain;
		check(act, 5'h00);
		// equal level stays pending, more urgent level pre-empts
		{lsvc, lpsv, ltick} = 6'h14;
		enter(10'h001);
		pulse(10'h002);
		wait_idle;
		check(act, `EPE_EXC_SVC);
		enter(10'h004);
		check(act, `EPE_EXC_TICK);
		chk_push(`EPE_EXC_SVC);
		drain;
		check(act, 5'h00);
		// fault inside hard fault locks up
		enter(10'h200);
		pulse(10'h080);
		wait_idle;
		check(lock, 1'b1);
		check(act, `EPE_EXC_HARD);
		for (int s = 0; s < 3; s++)
		begin
			{sw_rst, wd_rst, rpin_n} = {s == 0, s == 1, s != 2};
			step;
			step;
			{sw_rst, wd_rst, rpin_n} = 3'h1;
			wait_br;
			check(br_addr, 32'h8000_0004);
			check({lock, act}, 6'h00);
			step;
		end
		close_out;
	end
endmodule
